/* File: rtl/bce_branch_eval.sv */
// Branch condition evaluator with APB register access.
//
// Overview of operation
// RULE_01: Code 12 branches when selected flag bit is one; count untouched.
// RULE_02: Code 04 branches when selected flag bit is zero; count untouched.
// RULE_03: Code 08 decrements count; branch if nonzero and bit one.
// RULE_04: Code 00 decrements count; branch if nonzero and bit zero.
// RULE_05: Code 10 decrements count; branch if zero and bit one.
// RULE_06: Code 02 decrements count; branch if zero and bit zero.
// RULE_07: Code 18 decrements count; branch if zero, flags ignored.
// RULE_08: Bit selector picks one flag bit, 0 through 31.
// RULE_09: Flags are eight 4-bit fields; bit index is field times four plus position.
// RULE_10: Field positions mean less, greater, equal, overflow or unordered.
// RULE_11: Compare logic writes the flags; the branch unit only reads them. Here an APB write to BCE_OFF_FLAGS also loads them.
// RULE_12: Link form updates link register; absolute form uses target as address.
// RULE_13: Register-target forms jump to link or count register when taken.
// RULE_14: Link form writes the following instruction address, taken or not.
`timescale 1ns/1ps
`include "bce_params.svh"

module bce_branch_eval
    import bce_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic req_valid_in,
    input wire bce_req_s req_in,
    input wire logic cmp_we_in,
    input wire logic [2:0] cmp_field_in,
    input wire logic [3:0] cmp_bits_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic res_valid_out,
    output bce_res_s res_out
);
    // A narrower address bus could not tell the four registers apart.
    if (ADDR_W < 4) begin : g_addr_w_check
        $error("bce_branch_eval: ADDR_W must be at least 4");
    end

    logic [31:0] condition_flags_r, condition_flags_nxt;
    logic [31:0] loop_count_register_r, loop_count_register_nxt;
    logic [31:0] link_r, link_nxt;
    logic [1:0] status_r, status_nxt;
    logic res_valid_r, res_valid_nxt;
    bce_res_s res_r, res_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;

    // Evaluation terms.
    logic [4:0] bo;
    logic cond_bit;
    logic [31:0] count_dec;
    logic dec_en;
    logic branch_ok;
    logic bad_bo;
    logic [31:0] seq_pc;
    logic [31:0] tgt_addr;
    logic apb_wr;
    logic apb_rd;

    always_comb begin
        bo = req_in.branch_options_code;
        cond_bit = condition_flags_r[req_in.condition_bit_select]; // RULE_08 RULE_09 RULE_10
        count_dec = loop_count_register_r - 32'h0000_0001;
        dec_en = 1'b0;
        branch_ok = 1'b0;
        bad_bo = 1'b0;
        case (bo)
            `BCE_BO_TRUE: branch_ok = cond_bit; // RULE_01
            `BCE_BO_FALSE: branch_ok = ~cond_bit; // RULE_02
            `BCE_BO_DNZ_T: begin
                dec_en = 1'b1;
                branch_ok = (count_dec != 32'h0) && cond_bit; // RULE_03
            end
            `BCE_BO_DNZ_F: begin
                dec_en = 1'b1;
                branch_ok = (count_dec != 32'h0) && !cond_bit; // RULE_04
            end
            `BCE_BO_DZ_T: begin
                dec_en = 1'b1;
                branch_ok = (count_dec == 32'h0) && cond_bit; // RULE_05
            end
            `BCE_BO_DZ_F: begin
                dec_en = 1'b1;
                branch_ok = (count_dec == 32'h0) && !cond_bit; // RULE_06
            end
            `BCE_BO_DZ: begin
                dec_en = 1'b1;
                branch_ok = (count_dec == 32'h0); // RULE_07
            end
            `BCE_BO_ALWAYS: branch_ok = 1'b1;
            default: begin
                // Unlisted codes fall through and are flagged so software can see them.
                bad_bo = 1'b1;
            end
        endcase
        seq_pc = req_in.pc + 32'h0000_0004;
        case (req_in.tgt_kind)
            BCE_TGT_ABS: tgt_addr = req_in.target; // RULE_12
            BCE_TGT_LINK: tgt_addr = {link_r[31:2], 2'b00}; // RULE_13
            BCE_TGT_COUNT: tgt_addr = {loop_count_register_r[31:2], 2'b00}; // RULE_13
            default: tgt_addr = req_in.pc + req_in.target;
        endcase
    end

    assign apb_wr = psel_in && penable_in && pwrite_in && !pready_r;
    assign apb_rd = psel_in && penable_in && !pwrite_in && !pready_r;

    // Branch results and architectural registers.
    always_comb begin
        condition_flags_nxt = condition_flags_r;
        loop_count_register_nxt = loop_count_register_r;
        link_nxt = link_r;
        status_nxt = status_r;
        res_valid_nxt = req_valid_in;
        res_nxt = res_r;
        // Software writes come first so that a same-cycle branch update overrides them.
        if (apb_wr) begin
            if (paddr_in[ADDR_W-1:0] == ADDR_W'(`BCE_OFF_FLAGS)) begin
                condition_flags_nxt = pwdata_in;
            end else if (paddr_in[ADDR_W-1:0] == ADDR_W'(`BCE_OFF_COUNT)) begin
                loop_count_register_nxt = pwdata_in;
            end else if (paddr_in[ADDR_W-1:0] == ADDR_W'(`BCE_OFF_LINK)) begin
                link_nxt = pwdata_in;
            end else if (paddr_in[ADDR_W-1:0] == ADDR_W'(`BCE_OFF_STATUS)) begin
                status_nxt = status_r & ~pwdata_in[1:0];
            end
        end
        if (cmp_we_in) begin
            condition_flags_nxt[{cmp_field_in, 2'b00} +: 4] = cmp_bits_in; // RULE_11
        end
        if (req_valid_in) begin
            if (dec_en) begin
                loop_count_register_nxt = count_dec;
            end
            if (req_in.link_form) begin
                link_nxt = seq_pc; // RULE_14 RULE_12
            end
            res_nxt.taken = branch_ok && !bad_bo;
            res_nxt.next_pc = (branch_ok && !bad_bo) ? tgt_addr : seq_pc;
            res_nxt.link_we = req_in.link_form;
            res_nxt.link_val = seq_pc;
            status_nxt[`BCE_ST_TAKEN] = branch_ok && !bad_bo;
            status_nxt[`BCE_ST_BADBO] = status_nxt[`BCE_ST_BADBO] | bad_bo;
        end
    end

    // APB slave: one wait state, answer in the second access cycle.
    always_comb begin
        prdata_nxt = 32'h0;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        if (psel_in && penable_in && !pready_r) begin
            pready_nxt = 1'b1;
            if (paddr_in[ADDR_W-1:0] == ADDR_W'(`BCE_OFF_FLAGS)) begin
                prdata_nxt = condition_flags_r;
            end else if (paddr_in[ADDR_W-1:0] == ADDR_W'(`BCE_OFF_COUNT)) begin
                prdata_nxt = loop_count_register_r;
            end else if (paddr_in[ADDR_W-1:0] == ADDR_W'(`BCE_OFF_LINK)) begin
                prdata_nxt = link_r;
            end else if (paddr_in[ADDR_W-1:0] == ADDR_W'(`BCE_OFF_STATUS)) begin
                prdata_nxt = {30'h0, status_r};
            end else begin
                pslverr_nxt = 1'b1;
            end
            if (!apb_rd) begin
                prdata_nxt = 32'h0;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            condition_flags_r <= `BCE_FLAGS_RST;
            loop_count_register_r <= `BCE_COUNT_RST;
            link_r <= `BCE_LINK_RST;
            status_r <= 2'h0;
            res_valid_r <= 1'b0;
            res_r <= '0;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            condition_flags_r <= condition_flags_nxt;
            loop_count_register_r <= loop_count_register_nxt;
            link_r <= link_nxt;
            status_r <= status_nxt;
            res_valid_r <= res_valid_nxt;
            res_r <= res_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign res_valid_out = res_valid_r;
    assign res_out = res_r;

    a_true_taken: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_01
        req_valid_in && bo == `BCE_BO_TRUE |=> res_out.taken == $past(cond_bit)
        && (loop_count_register_r == $past(loop_count_register_r) || $past(apb_wr)))
        else $error("code 12 outcome wrong");
    a_false_taken: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_02
        req_valid_in && bo == `BCE_BO_FALSE |=> res_out.taken == !$past(cond_bit))
        else $error("code 04 outcome wrong");
    a_dnz_true: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_03
        req_valid_in && bo == `BCE_BO_DNZ_T |=> loop_count_register_r == $past(count_dec)
        && res_out.taken == ($past(count_dec) != 0 && $past(cond_bit)))
        else $error("code 08 outcome wrong");
    a_dnz_false: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_04
        req_valid_in && bo == `BCE_BO_DNZ_F
        |=> res_out.taken == ($past(count_dec) != 0 && !$past(cond_bit)))
        else $error("code 00 outcome wrong");
    a_dz_true: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_05
        req_valid_in && bo == `BCE_BO_DZ_T
        |=> res_out.taken == ($past(count_dec) == 0 && $past(cond_bit)))
        else $error("code 10 outcome wrong");
    a_dz_false: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_06
        req_valid_in && bo == `BCE_BO_DZ_F
        |=> res_out.taken == ($past(count_dec) == 0 && !$past(cond_bit)))
        else $error("code 02 outcome wrong");
    a_dz_only: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_07
        req_valid_in && bo == `BCE_BO_DZ
        |=> res_out.taken == ($past(loop_count_register_r) == 32'h1))
        else $error("code 18 outcome wrong");
    a_link_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_14
        req_valid_in && req_in.link_form |=> link_r == $past(req_in.pc) + 32'h4
        && res_valid_out && res_out.link_we)
        else $error("link not written with next address");
    a_abs_target: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_12
        req_valid_in && req_in.tgt_kind == BCE_TGT_ABS && branch_ok && !bad_bo
        |=> res_out.next_pc == $past(req_in.target))
        else $error("absolute target not used");
    a_cmp_field: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_11
        cmp_we_in |=> condition_flags_r[{$past(cmp_field_in), 2'b00} +: 4] == $past(cmp_bits_in))
        else $error("compare field not written");
    a_apb_ready: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        psel_in && penable_in && !pready_out |=> pready_out)
        else $error("apb answer late");
    a_false_count: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_02
        req_valid_in && bo == `BCE_BO_FALSE && !apb_wr
        |=> loop_count_register_r == $past(loop_count_register_r))
        else $error("code 04 changed the count");
    a_dnz_f_count: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_04
        req_valid_in && bo == `BCE_BO_DNZ_F
        |=> loop_count_register_r == $past(loop_count_register_r) - 32'h1)
        else $error("code 00 did not decrement the count");
    a_dz_t_count: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_05
        req_valid_in && bo == `BCE_BO_DZ_T
        |=> loop_count_register_r == $past(loop_count_register_r) - 32'h1)
        else $error("code 10 did not decrement the count");
    a_dz_f_count: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_06
        req_valid_in && bo == `BCE_BO_DZ_F
        |=> loop_count_register_r == $past(loop_count_register_r) - 32'h1)
        else $error("code 02 did not decrement the count");
    a_dz_count: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_07
        req_valid_in && bo == `BCE_BO_DZ
        |=> loop_count_register_r == $past(loop_count_register_r) - 32'h1)
        else $error("code 18 did not decrement the count");
    a_bit_select: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_09
        req_valid_in && bo == `BCE_BO_TRUE
        |=> res_out.taken == $past(condition_flags_r[{req_in.condition_bit_select[4:2], 2'b00}
        + 5'(req_in.condition_bit_select[1:0])]))
        else $error("wrong flag bit selected");
    a_flags_kept: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_11
        !cmp_we_in && !apb_wr |=> $stable(condition_flags_r))
        else $error("flags changed without a writer");
    a_link_target: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_13
        req_valid_in && req_in.tgt_kind == BCE_TGT_LINK && res_nxt.taken
        |=> res_out.next_pc == ($past(link_r) & 32'hffff_fffc))
        else $error("link register target not used");
    a_count_target: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE_13
        req_valid_in && req_in.tgt_kind == BCE_TGT_COUNT && res_nxt.taken
        |=> res_out.next_pc == ($past(loop_count_register_r) & 32'hffff_fffc))
        else $error("count register target not used");
    a_bad_code: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        req_valid_in && bad_bo |=> !res_out.taken && status_r[`BCE_ST_BADBO])
        else $error("bad option code not flagged");
    a_res_pulse: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        res_valid_out == $past(req_valid_in))
        else $error("result valid not one cycle after request");
    a_read_idle: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !pready_out |-> prdata_out == 32'h0 && !pslverr_out)
        else $error("apb answer outputs active outside answer");

    c_taken_loop: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
        req_valid_in && bo == `BCE_BO_DNZ_T ##1 res_out.taken);
    c_link_taken: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
        req_valid_in && req_in.link_form && req_in.tgt_kind == BCE_TGT_COUNT && branch_ok);
    c_apb_error: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
        pready_out && pslverr_out);
    c_count_zero: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
        req_valid_in && bo == `BCE_BO_DZ ##1 res_out.taken);
    c_bad_code: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
        req_valid_in && bad_bo);
endmodule : bce_branch_eval

/* File: rtl/bce_params.svh */
// Register offsets, field positions, reset values and operation codes of the branch evaluator.
`ifndef BCE_PARAMS_SVH
`define BCE_PARAMS_SVH
`define BCE_OFF_FLAGS 12'h000
`define BCE_OFF_COUNT 12'h004
`define BCE_OFF_LINK 12'h008
`define BCE_OFF_STATUS 12'h00c
`define BCE_FLAGS_RST 32'h0000_0000
`define BCE_COUNT_RST 32'h0000_0000
`define BCE_LINK_RST 32'h0000_0000
`define BCE_BO_TRUE 5'h0c
`define BCE_BO_FALSE 5'h04
`define BCE_BO_DNZ_T 5'h08
`define BCE_BO_DNZ_F 5'h00
`define BCE_BO_DZ_T 5'h0a
`define BCE_BO_DZ_F 5'h02
`define BCE_BO_DZ 5'h12
`define BCE_BO_ALWAYS 5'h14
`define BCE_FLD_LT 2'h0
`define BCE_FLD_GT 2'h1
`define BCE_FLD_EQ 2'h2
`define BCE_FLD_SO 2'h3
`define BCE_ST_TAKEN 0
`define BCE_ST_BADBO 1
`endif

/* File: rtl/bce_pkg.sv */
// Types shared by the branch condition evaluator.
package bce_pkg;
    typedef enum logic [1:0] {
        BCE_TGT_REL = 2'h0,
        BCE_TGT_ABS = 2'h1,
        BCE_TGT_LINK = 2'h2,
        BCE_TGT_COUNT = 2'h3
    } bce_tgt_e;

    typedef struct packed {
        logic [4:0] branch_options_code;
        logic [4:0] condition_bit_select;
        bce_tgt_e tgt_kind;
        logic link_form;
        logic [31:0] pc;
        logic [31:0] target;
    } bce_req_s;

    typedef struct packed {
        logic taken;
        logic [31:0] next_pc;
        logic link_we;
        logic [31:0] link_val;
    } bce_res_s;

    typedef enum logic [1:0] {
        BCE_IDLE = 2'b00,
        BCE_EVAL = 2'b01
    } bce_state_e;
endpackage : bce_pkg

/* File: tb/bce_cmp_model.sv */
// Compare-logic stand-in that writes condition fields into the evaluator.
`timescale 1ns/1ps
module bce_cmp_model (
    input wire logic clk_in,
    output logic cmp_we_out,
    output logic [2:0] cmp_field_out,
    output logic [3:0] cmp_bits_out
);
    initial begin
        cmp_we_out = 1'b0;
        cmp_field_out = 3'h0;
        cmp_bits_out = 4'h0;
    end

    // Field and bits are inverted once released so stale values never look valid.
    task automatic compare(input logic [2:0] f, input int a, input int b, input logic so);
        logic [3:0] bits;
        bits = {so, a == b, a > b, a < b};
        @(posedge clk_in);
        cmp_we_out <= 1'b1;
        cmp_field_out <= f;
        cmp_bits_out <= bits;
        @(posedge clk_in);
        cmp_we_out <= 1'b0;
        cmp_field_out <= ~f;
        cmp_bits_out <= ~bits;
    endtask : compare
endmodule : bce_cmp_model

/* File: tb/branch_condition_evaluator_test.sv */
// Self-checking bench for the branch condition evaluator.
`timescale 1ns/1ps
`include "bce_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module branch_condition_evaluator_test
    import bce_pkg::*;
;
    logic core_clk_in = 0, rstn_in = 0, req_valid_in = 0, cmp_we_in;
    logic psel_in = 0, penable_in = 0, pwrite_in = 0, pready_out, pslverr_out;
    logic res_valid_out, err;
    logic [2:0] cmp_field_in;
    logic [3:0] cmp_bits_in;
    logic [11:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, prdata_out, rd, seed = 32'h425c69c5;
    logic [31:0] mflags = 0, mcnt = 0, mlink = 0, mstat = 0;
    bce_req_s req_in = '0;
    bce_res_s res_out;
    int fails = 0, n_checks = 0, cyc = 0;
    logic [4:0] codes [9] = '{`BCE_BO_TRUE, `BCE_BO_FALSE, `BCE_BO_DNZ_T, `BCE_BO_DNZ_F,
        `BCE_BO_DZ_T, `BCE_BO_DZ_F, `BCE_BO_DZ, `BCE_BO_ALWAYS, 5'h01};

    bce_branch_eval #(.ADDR_W(12)) bce_branch_eval_i (.core_clk_in, .rstn_in,
        .req_valid_in, .req_in, .cmp_we_in, .cmp_field_in, .cmp_bits_in, .psel_in,
        .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
        .pslverr_out, .res_valid_out, .res_out);
    bce_cmp_model bce_cmp_model_i (.clk_in(core_clk_in), .cmp_we_out(cmp_we_in),
        .cmp_field_out(cmp_field_in), .cmp_bits_out(cmp_bits_in));

    initial forever #12.5 core_clk_in = ~core_clk_in;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test

    // The run is far shorter than this; reaching it means a lost handshake.
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        // Answer and data are taken at the edge that samples pready high.
        do @(posedge core_clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task automatic chk_regs();
        apb(0, `BCE_OFF_COUNT, 0);
        `CHK("count", mcnt, rd)
        apb(0, `BCE_OFF_LINK, 0);
        `CHK("link", mlink, rd)
        apb(0, `BCE_OFF_FLAGS, 0);
        `CHK("flags", mflags, rd)
        apb(0, `BCE_OFF_STATUS, 0);
        `CHK("status", mstat, rd)
    endtask : chk_regs

    task automatic send(input bce_req_s r);
        logic tk, c, z, dec;
        logic [31:0] npc;
        dec = r.branch_options_code inside {`BCE_BO_DNZ_T, `BCE_BO_DNZ_F, `BCE_BO_DZ_T,
            `BCE_BO_DZ_F, `BCE_BO_DZ};
        if (dec && r.tgt_kind == BCE_TGT_COUNT) r.tgt_kind = BCE_TGT_REL;
        if (dec) mcnt = mcnt - 1;
        z = (mcnt == 0);
        c = mflags[r.condition_bit_select];
        case (r.branch_options_code)
            `BCE_BO_TRUE: tk = c;
            `BCE_BO_FALSE: tk = !c;
            `BCE_BO_DNZ_T: tk = !z && c;
            `BCE_BO_DNZ_F: tk = !z && !c;
            `BCE_BO_DZ_T: tk = z && c;
            `BCE_BO_DZ_F: tk = z && !c;
            `BCE_BO_DZ: tk = z;
            `BCE_BO_ALWAYS: tk = 1'b1;
            default: begin
                tk = 1'b0;
                mstat[1] = 1'b1;
            end
        endcase
        case (r.tgt_kind)
            BCE_TGT_REL: npc = r.pc + r.target;
            BCE_TGT_ABS: npc = r.target;
            BCE_TGT_LINK: npc = mlink & ~32'h3;
            default: npc = mcnt & ~32'h3;
        endcase
        if (!tk) npc = r.pc + 32'h4;
        if (r.link_form) mlink = r.pc + 32'h4;
        mstat[0] = tk;
        @(posedge core_clk_in);
        req_valid_in <= 1'b1;
        req_in <= r;
        @(posedge core_clk_in);
        req_valid_in <= 1'b0;
        req_in <= ~r;
        #1;
        `CHK("res_valid", 1'b1, res_valid_out)
        `CHK("taken", tk, res_out.taken)
        if (dec) `CHK("taken_dec", tk, res_out.taken)
        `CHK("next_pc", npc, res_out.next_pc)
        `CHK("link_we", r.link_form, res_out.link_we)
        if (r.link_form) `CHK("link_val", r.pc + 32'h4, res_out.link_val)
    endtask : send

    initial begin
        bce_req_s r;
        logic [31:0] v;
        repeat (16) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        chk_regs();
        v = rnd();
        apb(1, `BCE_OFF_FLAGS, v);
        mflags = v;
        v = rnd();
        apb(1, `BCE_OFF_LINK, v);
        mlink = v;
        for (int i = 0; i < 450; i++) begin
            if (i % 8 == 0) begin
                v = (i % 16 == 0) ? rnd() : rnd() % 3;
                apb(1, `BCE_OFF_COUNT, v);
                mcnt = v;
            end
            if (i % 3 == 0) begin
                v = rnd();
                bce_cmp_model_i.compare(v[2:0], int'(v[5:4]), int'(v[7:6]), v[8]);
                mflags[{v[2:0], 2'b00} +: 4] = {v[8], v[5:4] == v[7:6], v[5:4] > v[7:6],
                    v[5:4] < v[7:6]};
            end
            v = rnd();
            r.branch_options_code = codes[i % 9];
            r.condition_bit_select = v[4:0];
            r.tgt_kind = bce_tgt_e'(v[6:5]);
            r.link_form = v[7];
            r.pc = rnd() & ~32'h3;
            r.target = rnd();
            send(r);
            if (i % 40 == 0) chk_regs();
        end
        chk_regs();
        apb(1, `BCE_OFF_STATUS, 32'h2);
        mstat[1] = 1'b0;
        chk_regs();
        apb(1, 12'h010, rnd());
        `CHK("wr_unmapped_err", 1'b1, err)
        apb(0, 12'h010, 0);
        `CHK("rd_unmapped_err", 1'b1, err)
        `CHK("rd_unmapped_data", 32'h0, rd)
        end_of_test();
    end
endmodule : branch_condition_evaluator_test
